// ### dv/wide_timer_core_byte_access_bench.sv
`timescale 1ns/100ps
`default_nettype none
module wide_timer_core_byte_access_bench;
  import wtc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock;
  logic rst;
  logic ce;
  logic ext_count_pin;
  logic capture_input_pin;
  logic comp_out;
  wtc_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic [1:0] compare_output_pins;
  logic prescaler_reset_out;
  logic irq;
  int error_cnt = 0; // Mismatches
  int checks = 0; // Comparisons made
  logic [15:0] v; // Last 16-bit read
  logic [7:0] b; // Last byte read
  int hits; // Cycles a pulse was seen high
  // Direct byte registers: address, data written, data read back
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } wtc_row_s;
  wtc_row_s rows [9] = '{
    '{OFS_CTRL_A, 8'h03, 8'h03}, '{OFS_CTRL_A, 8'h00, 8'h00}, '{OFS_CTRL_B, 8'hE0, 8'hE0},
    '{OFS_CTRL_B, 8'h00, 8'h00}, '{OFS_MASK, 8'h0F, 8'h0F}, '{OFS_MASK, 8'h00, 8'h00},
    '{OFS_POWER, 8'h01, 8'h01}, '{OFS_POWER, 8'h00, 8'h00}, '{4'hE, 8'h5A, 8'h00}};
  // Counting modes: control A, control B high bits, start count, top
  typedef struct packed {
    logic [7:0] ca;
    logic [7:0] cb;
    logic [15:0] start;
    logic [15:0] top;
  } wtc_mode_s;
  wtc_mode_s modes [4] = '{
    '{8'h01, 8'h00, 16'h00F8, TOP_8BIT}, '{8'h02, 8'h00, 16'h01F8, TOP_9BIT},
    '{8'h03, 8'h00, 16'h03F8, TOP_10BIT}, '{8'h03, 8'h18, 16'h0018, 16'h0020}};

  // ----------------------------------------------------------------
  // Design and processor model
  // ----------------------------------------------------------------
  wtc_core u_wtc_core (
    .clock(clock), .rst(rst), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .ext_count_pin(ext_count_pin), .capture_input_pin(capture_input_pin),
    .comp_out(comp_out), .compare_output_pins(compare_output_pins),
    .prescaler_reset_out(prescaler_reset_out), .irq(irq));
  wtc_cpu_model u_wtc_cpu_model (.clock(clock), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // Free-running 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    u_wtc_cpu_model.wr(a, d);
  endtask
  task automatic r(input logic [3:0] a);
    u_wtc_cpu_model.rd(a, b);
  endtask
  task automatic w16(input logic [3:0] a, input logic [15:0] d);
    u_wtc_cpu_model.wr16(a, d);
  endtask
  task automatic r16(input logic [3:0] a);
    u_wtc_cpu_model.rd16(a, v);
  endtask
  // Compare, count, report a mismatch at once
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bounded wait for the interrupt; a hang ends the run as a failure
  task automatic wait_irq();
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clock);
    if (irq !== 1'b1) begin
      chk("irq wait", 16'(irq), 16'h0001);
      results();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    ext_count_pin = 1'b0;
    capture_input_pin = 1'b0;
    comp_out = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Reset state
    #1;
    chk("irq", 16'(irq), 16'h0000);
    chk("psr out", 16'(prescaler_reset_out), 16'h0000);
    r16(OFS_CNT_L);
    chk("count", v, CNT_FLOOR);
    $display("test reset done");
    // Byte registers through a slow core
    u_wtc_cpu_model.gap = 2;
    foreach (rows[i]) begin
      w(rows[i].addr, rows[i].wdata);
      r(rows[i].addr);
      chk("byte reg", 16'(b), 16'(rows[i].exp));
    end
    u_wtc_cpu_model.gap = 0;
    // Frozen core ignores a strobe
    @(posedge clock);
    ce <= 1'b0;
    w(OFS_MASK, 8'h0F);
    ce <= 1'b1;
    r(OFS_MASK);
    chk("frozen wr", 16'(b), 16'h0000);
    $display("test registers done");
    // One temporary shared by all; stopped counter holds
    w(OFS_CNT_H, 8'h12);
    w(OFS_CNT_L, 8'h34);
    w(OFS_CMPA_L, 8'h56);
    repeat (20) @(posedge clock);
    r16(OFS_CNT_L);
    chk("count", v, 16'h1234);
    r16(OFS_CMPA_L);
    chk("cmp a", v, 16'h1256);
    // Compare reads bypass the temporary
    w16(OFS_CMPA_L, 16'h5678);
    r(OFS_CNT_L);
    r16(OFS_CMPA_L);
    chk("cmp a", v, 16'h5678);
    r(OFS_CNT_H);
    chk("temp", 16'(b), 16'h0012);
    $display("test byte access done");
    // Wrap through max with both matches on the way
    w16(OFS_CNT_L, 16'hFFF0);
    w16(OFS_CMPA_L, 16'hFFF4);
    w16(OFS_CMPB_L, 16'hFFF6);
    w(OFS_MASK, 8'h01);
    w(OFS_CTRL_B, 8'h01);
    wait_irq();
    chk("pins", 16'(compare_output_pins), 16'h0003);
    w16(OFS_CNT_L, 16'h0100);
    r16(OFS_CNT_L);
    chk("count hi", 16'(v[15:8]), 16'h0001);
    w(OFS_CTRL_B, 8'h00);
    r(OFS_FLAGS);
    chk("flags", 16'(b), 16'h0007);
    w(OFS_MASK, 8'h00);
    #1;
    chk("irq", 16'(irq), 16'h0000);
    w(OFS_MASK, 8'h02);
    #1;
    chk("irq", 16'(irq), 16'h0001);
    w(OFS_FLAGS, 8'h02);
    #1;
    chk("irq", 16'(irq), 16'h0000);
    r(OFS_FLAGS);
    chk("flags", 16'(b), 16'h0005);
    w(OFS_FLAGS, 8'h0F);
    $display("test compare done");
    // Fixed tops and compare A as top; overflow marks the top
    w16(OFS_CMPA_L, 16'h0020);
    w(OFS_MASK, 8'h01);
    foreach (modes[i]) begin
      w(OFS_CTRL_A, modes[i].ca);
      w(OFS_CTRL_B, modes[i].cb);
      w16(OFS_CNT_L, modes[i].start);
      w(OFS_FLAGS, 8'h0F);
      w(OFS_CTRL_B, modes[i].cb | 8'h01);
      wait_irq();
      w(OFS_CTRL_B, modes[i].cb);
      r16(OFS_CNT_L);
      chk("under top", 16'(v <= modes[i].top), 16'h0001);
      if (modes[i].cb[4]) chk("pin a", 16'(compare_output_pins[0]), 16'h0000);
    end
    w(OFS_CTRL_A, 8'h00);
    w(OFS_CTRL_B, 8'h00);
    w(OFS_FLAGS, 8'h0F);
    $display("test top done");
    // Power off: no counting
    w(OFS_POWER, 8'h01);
    w16(OFS_CNT_L, 16'h0000);
    w(OFS_CTRL_B, 8'h01);
    repeat (20) @(posedge clock);
    w(OFS_CTRL_B, 8'h00);
    r16(OFS_CNT_L);
    chk("count", v, 16'h0000);
    w(OFS_POWER, 8'h00);
    // Prescaler reset pulse, then held under sync hold
    w(OFS_GCTRL, 8'h01);
    hits = 0;
    repeat (4) begin
      #1;
      if (prescaler_reset_out === 1'b1) hits++;
      @(posedge clock);
    end
    chk("psr pulse", 16'(hits), 16'h0001);
    r(OFS_GCTRL);
    chk("gctrl", 16'(b), 16'h0000);
    w(OFS_GCTRL, 8'h81);
    w(OFS_CTRL_B, 8'h02);
    repeat (40) @(posedge clock);
    r16(OFS_CNT_L);
    chk("count", v, 16'h0000);
    r(OFS_GCTRL);
    chk("gctrl", 16'(b), 16'h0081);
    w(OFS_GCTRL, 8'h00);
    r(OFS_GCTRL);
    chk("gctrl", 16'(b), 16'h0000);
    repeat (40) @(posedge clock);
    w(OFS_CTRL_B, 8'h00);
    r16(OFS_CNT_L);
    chk("counting", 16'(v != 16'h0000), 16'h0001);
    $display("test prescaler done");
    // External pin, rising then falling edge, three pulses each
    for (int i = 0; i < 2; i++) begin
      w16(OFS_CNT_L, 16'h0000);
      w(OFS_CTRL_B, 8'(i == 0 ? CS_EXT_RISE : CS_EXT_FALL));
      repeat (3) begin
        @(posedge clock);
        ext_count_pin <= 1'b1;
        repeat (4) @(posedge clock);
        ext_count_pin <= 1'b0;
        repeat (4) @(posedge clock);
      end
      repeat (8) @(posedge clock);
      w(OFS_CTRL_B, 8'h00);
      r16(OFS_CNT_L);
      chk("ext count", v, 16'h0003);
    end
    $display("test ext clock done");
    // Capture from the pin, rising edge, no filter
    w16(OFS_CNT_L, 16'h4321);
    w(OFS_CTRL_B, 8'h40);
    @(posedge clock);
    capture_input_pin <= 1'b1;
    repeat (8) @(posedge clock);
    r(OFS_FLAGS);
    chk("flags", 16'(b), 16'h0008);
    r16(OFS_CAP_L);
    chk("capture", v, 16'h4321);
    // Comparator source through the filter: a short glitch is dropped
    w(OFS_FLAGS, 8'h08);
    w16(OFS_CNT_L, 16'h5555);
    w(OFS_CTRL_B, 8'hE0);
    @(posedge clock);
    comp_out <= 1'b1;
    repeat (2) @(posedge clock);
    comp_out <= 1'b0;
    repeat (12) @(posedge clock);
    r(OFS_FLAGS);
    chk("flags", 16'(b), 16'h0000);
    comp_out <= 1'b1;
    repeat (16) @(posedge clock);
    r(OFS_FLAGS);
    chk("flags", 16'(b), 16'h0008);
    r16(OFS_CAP_L);
    chk("capture", v, 16'h5555);
    $display("test capture done");
    results();
  end
endmodule // wide_timer_core_byte_access_bench
`default_nettype wire

// ### dv/wtc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Processor core model: master of the 8-bit register bus
// ----------------------------------------------------------------
module wtc_cpu_model
  import wtc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register bus
  output var wtc_pkg::wtc_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata
);
  int gap = 0; // Idle cycles after each access, models a slow core

  initial bus_req = '0;

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
    repeat (gap) @(posedge clock);
  endtask

  // One-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1;
    d = bus_rdata;
    repeat (gap) @(posedge clock);
  endtask

  // 16-bit write: high byte parks in the shared temporary first
  task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
    wr(4'(lo + 4'h1), d[15:8]);
    wr(lo, d[7:0]);
  endtask

  // 16-bit read: low byte first latches the high byte
  task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(4'(lo + 4'h1), d[15:8]);
  endtask
endmodule // wtc_cpu_model
`default_nettype wire

// ### hdl/wtc_core.sv
// Overview of operation
// - Prescaler reset bit restarts shared prescaler
// - Reset bit self-clears unless sync hold set
// - Timer runs only while power-off bit zero
// - Clock select picks prescaler tap or pin edge
// - Both compare values matched continuously, set flags
// - Qualified capture edge stores counter, optionally filtered
// - Floor is 0x0000, max is 0xFFFF
// - Top fixed 8/9/10-bit, compare A or capture
// - Compare A as top in PWM: no output, buffered
// - One shared temporary high byte register
// - Low byte write loads temp and low together
// - Low byte read latches high byte into temp
// - Compare reads bypass the temporary register
// - Control registers accessed directly, no ordering
// - Four flags in one register, individually masked
// - Clearing sync hold clears held reset bit
// - Processor counter write beats count or clear
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module wtc_core (
  // Clock, reset and freeze
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Processor register port
  input wire wtc_pkg::wtc_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  // Pins and comparator
  input wire logic ext_count_pin,
  input wire logic capture_input_pin,
  input wire logic comp_out,
  // Outputs
  output logic [1:0] compare_output_pins,
  output logic prescaler_reset_out,
  output logic irq
);
  import wtc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wtc_state_s q_reg; // All state of the block
  wtc_state_s q_next; // Its next value
  logic [3:0] wgm; // Waveform mode
  logic [2:0] cs; // Clock select
  logic tap; // Selected source fires this cycle
  logic tick; // Counter may advance this cycle
  logic pwm; // Mode buffers compare values
  logic cap_is_top; // Capture register defines top
  logic a_is_top; // Compare A defines top
  logic [15:0] top; // Current top value
  logic wrap; // Counter at top on a tick
  logic match_a; // Compare A match on a tick
  logic match_b; // Compare B match on a tick
  logic sample; // Synchronised capture source
  logic cap_evt; // Qualified capture event
  logic [3:0] set_flags; // Hardware flag sets this cycle
  logic wr_cnt; // Processor writes counter low byte

  assign wgm = {q_reg.ctrl_b[4:3], q_reg.ctrl_a[1:0]};
  assign cs = q_reg.ctrl_b[2:0];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Top value and buffering per waveform mode
  always_comb begin
    pwm = 1'b1;
    cap_is_top = 1'b0;
    a_is_top = 1'b0;
    top = CNT_MAX; // Normal mode runs floor to max
    unique case (wgm)
      4'h1, 4'h5: top = TOP_8BIT;
      4'h2, 4'h6: top = TOP_9BIT;
      4'h3, 4'h7: top = TOP_10BIT;
      4'h4: begin
        pwm = 1'b0; // Clear on match uses compare A directly
        a_is_top = 1'b1;
        top = q_reg.cmp_a;
      end
      4'hC: begin
        pwm = 1'b0;
        cap_is_top = 1'b1;
        top = q_reg.cap;
      end
      4'h8, 4'hA, 4'hE: begin
        cap_is_top = 1'b1;
        top = q_reg.cap;
      end
      4'h9, 4'hB, 4'hF: begin
        a_is_top = 1'b1;
        top = q_reg.cmp_a;
      end
      4'h0, 4'hD: pwm = 1'b0;
      default: pwm = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock select
  // ----------------------------------------------------------------
  // Prescaler taps use all-ones of the low bits, one cycle per period
  always_comb begin
    unique case (cs)
      3'h1: tap = 1'b1;
      3'h2: tap = &q_reg.pre[2:0];
      3'h3: tap = &q_reg.pre[5:0];
      3'h4: tap = &q_reg.pre[7:0];
      3'h5: tap = &q_reg.pre[9:0];
      // Pin edges come from the second and third flop, never the first
      CS_EXT_FALL: tap = q_reg.ext_sync[2] & ~q_reg.ext_sync[1];
      CS_EXT_RISE: tap = ~q_reg.ext_sync[2] & q_reg.ext_sync[1];
      default: tap = 1'b0;
    endcase
  end

  // Powered-off timer never counts
  assign tick = tap & ~q_reg.pwr_off;
  assign wrap = tick & (q_reg.cnt == top);
  assign match_a = tick & (q_reg.cnt == q_reg.cmp_a);
  assign match_b = tick & (q_reg.cnt == q_reg.cmp_b);
  assign wr_cnt = bus_req.wr & (bus_req.addr == OFS_CNT_L);

  // ----------------------------------------------------------------
  // Capture source and filter
  // ----------------------------------------------------------------
  assign sample = q_reg.ctrl_b[BIT_CAP_SRC] ? q_reg.ac_sync[1] : q_reg.pin_sync[1];

  // Event when the filtered level changes towards the chosen edge
  always_comb begin
    logic lvl;
    lvl = q_reg.cap_level;
    if (!q_reg.ctrl_b[BIT_CAP_FILT]) begin
      lvl = sample;
    end else if (&{q_reg.filt, sample} || ~|{q_reg.filt, sample}) begin
      lvl = sample; // Filter adds latency of its depth
    end
    cap_evt = (lvl != q_reg.cap_level) & (lvl == q_reg.ctrl_b[BIT_CAP_EDGE])
            & ~cap_is_top & ~q_reg.pwr_off;
  end

  assign set_flags = {cap_evt, match_b, match_a,
                      wrap & (pwm | (q_reg.cnt == CNT_MAX))};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    // Synchronisers; first flops feed only the second
    q_next.ext_sync = {q_reg.ext_sync[1:0], ext_count_pin};
    q_next.pin_sync = {q_reg.pin_sync[0], capture_input_pin};
    q_next.ac_sync = {q_reg.ac_sync[0], comp_out};
    q_next.filt = {q_reg.filt[FILT_N-2:0], sample};
    if (!q_reg.ctrl_b[BIT_CAP_FILT] || &{q_reg.filt, sample} ||
        ~|{q_reg.filt, sample}) begin
      q_next.cap_level = sample;
    end

    // Shared prescaler runs even when this timer is off
    if (q_reg.psr) begin
      q_next.pre = '0;
    end else begin
      q_next.pre = q_reg.pre + 1'b1;
    end
    // Reset bit drops after one cycle unless hold keeps it
    if (!q_reg.hold) begin
      q_next.psr = 1'b0;
    end

    // Counter: wrap to floor at top, else count up
    if (wrap) begin
      q_next.cnt = CNT_FLOOR;
    end else if (tick) begin
      q_next.cnt = q_reg.cnt + 1'b1;
    end

    // Buffered compares load at wrap in PWM modes, else at once
    if (!pwm || wrap) begin
      q_next.cmp_a = q_reg.buf_a;
      q_next.cmp_b = q_reg.buf_b;
    end

    // Capture stores the counter as it stands
    if (cap_evt) begin
      q_next.cap = q_reg.cnt;
    end

    // Waveform: A is silent while it defines top in PWM
    if (pwm) begin
      if (wrap) begin
        q_next.oc = 2'h3;
      end
      if (match_a) begin
        q_next.oc[0] = 1'b0;
      end
      if (match_b) begin
        q_next.oc[1] = 1'b0;
      end
      if (a_is_top) begin
        q_next.oc[0] = 1'b0;
      end
    end else begin
      q_next.oc = q_reg.oc ^ {match_b, match_a};
    end

    // Flags: set wins over a write-one clear in the same cycle
    q_next.flags = q_reg.flags | set_flags;

    // Register writes; counter write comes last so it wins
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        OFS_CTRL_A: q_next.ctrl_a = bus_req.wdata;
        OFS_CTRL_B: q_next.ctrl_b = bus_req.wdata;
        OFS_CNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H:
          q_next.temp = bus_req.wdata;
        OFS_CNT_L: q_next.cnt = {q_reg.temp, bus_req.wdata};
        OFS_CMPA_L: q_next.buf_a = {q_reg.temp, bus_req.wdata};
        OFS_CMPB_L: q_next.buf_b = {q_reg.temp, bus_req.wdata};
        OFS_CAP_L: q_next.cap = {q_reg.temp, bus_req.wdata};
        OFS_FLAGS: q_next.flags = (q_reg.flags & ~bus_req.wdata[3:0]) | set_flags;
        OFS_MASK: q_next.mask = bus_req.wdata[3:0];
        OFS_GCTRL: begin
          q_next.hold = bus_req.wdata[BIT_HOLD];
          if (bus_req.wdata[BIT_PSR]) begin
            q_next.psr = 1'b1;
          end else if (!bus_req.wdata[BIT_HOLD]) begin
            q_next.psr = 1'b0;
          end
          // Dropping hold releases a held reset at once
          if (!bus_req.wdata[BIT_HOLD] && q_reg.hold) begin
            q_next.psr = 1'b0;
          end
        end
        OFS_POWER: q_next.pwr_off = bus_req.wdata[BIT_PWR_OFF];
        default: ; // Unmapped writes are dropped
      endcase
    end

    // Reads: registered answer the cycle after the strobe
    q_next.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_CTRL_A: q_next.rdata = q_reg.ctrl_a;
        OFS_CTRL_B: q_next.rdata = q_reg.ctrl_b;
        OFS_CNT_L: begin
          q_next.rdata = q_reg.cnt[7:0];
          q_next.temp = q_reg.cnt[15:8];
        end
        OFS_CAP_L: begin
          q_next.rdata = q_reg.cap[7:0];
          q_next.temp = q_reg.cap[15:8];
        end
        OFS_CNT_H, OFS_CAP_H: q_next.rdata = q_reg.temp;
        // Compare reads show the live values and leave temp alone
        OFS_CMPA_L: q_next.rdata = q_reg.cmp_a[7:0];
        OFS_CMPA_H: q_next.rdata = q_reg.cmp_a[15:8];
        OFS_CMPB_L: q_next.rdata = q_reg.cmp_b[7:0];
        OFS_CMPB_H: q_next.rdata = q_reg.cmp_b[15:8];
        OFS_FLAGS: q_next.rdata = {4'h0, q_reg.flags};
        OFS_MASK: q_next.rdata = {4'h0, q_reg.mask};
        OFS_GCTRL: q_next.rdata = {q_reg.hold, 6'h00, q_reg.psr};
        OFS_POWER: q_next.rdata = {7'h00, q_reg.pwr_off};
        default: q_next.rdata = 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clock enable low freezes every bit, synchronisers included
  always_ff @(posedge clock) begin
    if (rst) begin
      q_reg <= WTC_STATE_RST;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rdata = q_reg.rdata;
  assign compare_output_pins = q_reg.oc;
  assign prescaler_reset_out = q_reg.psr; // Shared with timer zero
  assign irq = |(q_reg.flags & q_reg.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_psr_clears_pre: assert property (q_reg.psr && ce |=> q_reg.pre == '0)
    else $error("prescaler not cleared by reset bit");
  a_psr_self_clear: assert property (
    q_reg.psr && !q_reg.hold && ce && !bus_req.wr |=> !q_reg.psr)
    else $error("prescaler reset bit did not self clear");
  a_hold_release: assert property (
    ce && q_reg.hold && bus_req.wr && bus_req.addr == OFS_GCTRL
    && bus_req.wdata == 8'h00 |=> !q_reg.psr && !q_reg.hold)
    else $error("hold release left reset bit set");
  a_power_freeze: assert property (
    ce && q_reg.pwr_off && !wr_cnt |=> $stable(q_reg.cnt))
    else $error("counter moved while powered off");
  a_stopped_hold: assert property (
    (ce && cs == CS_NONE && !wr_cnt) [*2] |=> $stable(q_reg.cnt))
    else $error("counter moved with no clock source");
  a_cmp_a_flag: assert property (
    ce && tick && q_reg.cnt == q_reg.cmp_a |=> q_reg.flags[FLG_CMPA])
    else $error("compare A match lost");
  a_cap_store: assert property (
    ce && cap_evt && !bus_req.wr |=> q_reg.cap == $past(q_reg.cnt) && q_reg.flags[FLG_CAP])
    else $error("capture value or flag wrong");
  a_low_write: assert property (
    ce && wr_cnt |=> q_reg.cnt == {$past(q_reg.temp), $past(bus_req.wdata)})
    else $error("low write did not load both bytes");
  a_low_read: assert property (
    ce && bus_req.rd && bus_req.addr == OFS_CNT_L
    |=> q_reg.temp == $past(q_reg.cnt[15:8]) && bus_rdata == $past(q_reg.cnt[7:0]))
    else $error("low read did not latch high byte");
  a_cmp_read: assert property (
    ce && bus_req.rd && bus_req.addr == OFS_CMPA_H
    |=> bus_rdata == $past(q_reg.cmp_a[15:8]) && $stable(q_reg.temp))
    else $error("compare read used temporary register");
  a_top_wrap: assert property (
    ce && wrap && !wr_cnt |=> q_reg.cnt == CNT_FLOOR)
    else $error("counter did not wrap at top");
  a_irq_level: assert property (
    q_reg.flags[FLG_OVF] && q_reg.mask[FLG_OVF] |-> irq)
    else $error("unmasked flag gave no interrupt");

  c_overflow: cover property (ce && wrap && q_reg.cnt == CNT_MAX);
  c_capture: cover property (ce && cap_evt);
  c_hold_cycle: cover property (q_reg.hold && q_reg.psr ##[1:50] !q_reg.hold);
  c_pwm_b: cover property (pwm && match_b);

endmodule // wtc_core
`default_nettype wire

// ### shared/wtc_pkg.sv
`default_nettype none
package wtc_pkg;
  // ----------------------------------------------------------------
  // Register offsets on the 8-bit processor bus
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h1;
  localparam logic [3:0] OFS_CNT_L = 4'h2;
  localparam logic [3:0] OFS_CNT_H = 4'h3;
  localparam logic [3:0] OFS_CMPA_L = 4'h4;
  localparam logic [3:0] OFS_CMPA_H = 4'h5;
  localparam logic [3:0] OFS_CMPB_L = 4'h6;
  localparam logic [3:0] OFS_CMPB_H = 4'h7;
  localparam logic [3:0] OFS_CAP_L = 4'h8;
  localparam logic [3:0] OFS_CAP_H = 4'h9;
  localparam logic [3:0] OFS_FLAGS = 4'hA;
  localparam logic [3:0] OFS_MASK = 4'hB;
  localparam logic [3:0] OFS_GCTRL = 4'hC;
  localparam logic [3:0] OFS_POWER = 4'hD;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PSR = 0;     // Shared prescaler reset, general control
  localparam int BIT_HOLD = 7;    // Sync hold mode, general control
  localparam int BIT_PWR_OFF = 0; // Timer power off, power register
  localparam int BIT_CAP_SRC = 5; // Control B: capture from comparator
  localparam int BIT_CAP_EDGE = 6; // Control B: capture on rising edge
  localparam int BIT_CAP_FILT = 7; // Control B: noise filter on
  localparam int FLG_OVF = 0;     // Overflow flag
  localparam int FLG_CMPA = 1;    // Compare match A flag
  localparam int FLG_CMPB = 2;    // Compare match B flag
  localparam int FLG_CAP = 3;     // Capture flag
  // ----------------------------------------------------------------
  // Counter boundaries and clock select codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_FLOOR = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;      // Prescaler width, largest divide 1024
  localparam int FILT_N = 4;      // Filter history depth; the noise filter needs five equal samples
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } wtc_bus_req_s;
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [2:0] ext_sync;
    logic [1:0] pin_sync;
    logic [1:0] ac_sync;
    logic [FILT_N-1:0] filt;
    logic cap_level;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] cap;
    logic [7:0] temp;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [3:0] flags;
    logic [3:0] mask;
    logic hold;
    logic psr;
    logic pwr_off;
    logic [7:0] rdata;
    logic [1:0] oc;
  } wtc_state_s;
  localparam wtc_state_s WTC_STATE_RST = '0;
endpackage
`default_nettype wire
